// ---- tas_regs.vh ----
// Constants for the tag command handler: register map, field positions, opcodes, answers, timing.
// Included by the design files; holds definitions only.
`ifndef TAS_REGS_VH
`define TAS_REGS_VH

// ************************************************
// Register offsets (byte addresses)
// ************************************************
`define TAS_OFS_CFG 8'h00
`define TAS_OFS_PWD 8'h04
`define TAS_OFS_ID 8'h08
`define TAS_OFS_STAT 8'h0C
`define TAS_OFS_SESS 8'h10

// ************************************************
// Fields and reset values
// ************************************************
`define TAS_CFG_START_LSB 0
`define TAS_CFG_SCOPE_BIT 8
`define TAS_CFG_LIMIT_LSB 9
`define TAS_CFG_RST 32'h0000_00FF
`define TAS_PWD_RST 32'hFFFF_FFFF
`define TAS_PACK_RST 16'h0000
`define TAS_STAT_LOCK_BIT 4
`define TAS_STAT_BUSY_BIT 5

// ************************************************
// Opcodes, frame lengths incl. CRC, answers
// ************************************************
`define TAS_OP_PWD 8'h1B
`define TAS_OP_SIG 8'h3C
`define TAS_OP_TEAR 8'h3E
`define TAS_OP_VIRTUAL_CARD_SELECT_COMMAND 8'h4B
`define TAS_LEN_PWD 6'h07
`define TAS_LEN_SIG 6'h04
`define TAS_LEN_TEAR 6'h04
`define TAS_LEN_VIRTUAL_CARD_SELECT_COMMAND 6'h17
`define TAS_SIG_ADDR 8'h00
`define TAS_TEAR_MAX 8'h02
`define TAS_NAK_ARG 4'h0
`define TAS_NAK_CRC 4'h1
`define TAS_NAK_AUTH 4'h4
`define TAS_CRC_INIT 16'h6363
`define TAS_CRC_POLY 16'h8408

// ************************************************
// Timing
// ************************************************
`define TAS_CLK_NS 10
`define TAS_FDT_NS 91150
`define TAS_TIMEOUT_NS 5000000
`define TAS_FDT_CYC ((`TAS_FDT_NS + `TAS_CLK_NS - 1) / `TAS_CLK_NS)

`endif

// ---- tas_crc.v ----
// CRC of the contactless frame, one byte per enable, reflected form.
// Assumes the caller feeds bytes in link order, least significant bit first.
`timescale 1ns/10ps
`include "tas_regs.vh"

module tas_crc (
  input wire clk_i, // System clock
  input wire rst_i, // Synchronous reset
  input wire clr_i, // Reload initial value
  input wire en_i, // Absorb one byte
  input wire [7:0] byte_i, // Byte to absorb
  output reg [15:0] crc_o // Running CRC
);

  function [15:0] crc_step;
    input [15:0] c;
    input [7:0] b;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1)
      begin
        t = t[0] ? ((t >> 1) ^ `TAS_CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  always @(posedge clk_i)
  begin
    if (rst_i || clr_i)
    begin
      crc_o <= `TAS_CRC_INIT;
    end
    else if (en_i)
    begin
      crc_o <= crc_step(crc_o, byte_i);
    end
  end

endmodule // tas_crc

// ---- tas_cmd.v ----
// Command handler for password check, signature read, tear check and virtual card select.
// Assumes a bit-serial link from the reader clocked by link_clk_i; Wishbone classic slave for setup.
// Behaviour
// - Pages at or above protect_start_page need a passed password check.
// - Protection scope bit picks write-only or read-and-write guarding.
// - Password check frame carries four password bytes; match answers two-byte acknowledge value.
// - With nonzero failed_attempt_limit each failed check is counted, update made atomically.
// - At the limit the access chosen by the scope bit stays refused for good; here rst_i clears fail_r and lifts the lock.
// - Every answer waits at least the n=9 slot; reader times out after 5 ms.
// - Signature read needs address 00h and returns the 32-byte chip signature.
// - Signature is a build-time constant that no command can change.
// - Tear check takes counter number 0 to 2 and returns one flag byte.
// - Flag byte BDh means intact; anything else means a torn update.
// - Counter read still returns last valid value after tearing.
// - Virtual card select takes 16-byte identifier, 4-byte capability word, answers type code.
// - Identifier and capability contents ignored; only byte count checked.
// - Frames end in a two-byte CRC checked before executing.
// - Unauthenticated writes at or above start page refused; after authentication unprotected.
// - One-way counters stay readable whatever the protection settings.
`timescale 1ns/10ps
`include "tas_regs.vh"

module tas_cmd #(
  parameter FDT_CYC = `TAS_FDT_CYC, // Least wait from frame end to answer
  parameter [255:0] SIG_VALUE = {8{32'hA5C3_5A3C}}, // Arbitrary value, set per chip at build
  parameter [7:0] VIRTUAL_CARD_TYPE_CODE_RST = 8'h00 // Arbitrary default type code
) (
  input wire clk_i, // System clock
  input wire rst_i, // Synchronous reset
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte enables
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire link_clk_i, // Link bit clock from reader
  input wire link_frm_i, // Reader frame active
  input wire link_dat_i, // Reader data bit
  output reg tx_frm_o, // Answer frame active
  output reg tx_dat_o, // Answer data bit
  input wire [23:0] tear_flag_i, // Flag byte per counter, counter 0 low
  input wire [7:0] page_i, // Page of a pending memory access
  output wire wr_ok_o, // Write to page_i allowed
  output wire rd_ok_o // Read of page_i allowed
);

  localparam ST_IDLE = 2'd0;
  localparam ST_RX = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_TX = 2'd3;
  localparam RSP_NAK = 3'd0;
  localparam RSP_PACK = 3'd1;
  localparam RSP_SIG = 3'd2;
  localparam RSP_TEAR = 3'd3;
  localparam RSP_VCT = 3'd4;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
      begin
        if (sel[k])
        begin
          merge[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  // ************************************************
  // Link input synchronisers and edge detect
  // ************************************************
  reg [2:0] clk_s_r;
  reg [2:0] frm_s_r;
  reg [1:0] dat_s_r;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_s_r <= 3'b000;
      frm_s_r <= 3'b000;
      dat_s_r <= 2'b00;
    end
    else
    begin
      clk_s_r <= {clk_s_r[1:0], link_clk_i};
      frm_s_r <= {frm_s_r[1:0], link_frm_i};
      dat_s_r <= {dat_s_r[0], link_dat_i};
    end
  end
  wire lk_rise = clk_s_r[1] & ~clk_s_r[2];
  wire lk_fall = ~clk_s_r[1] & clk_s_r[2];
  wire frm_on = frm_s_r[1];
  wire frm_end = ~frm_s_r[1] & frm_s_r[2];
  wire frm_beg = frm_s_r[1] & ~frm_s_r[2];

  // ************************************************
  // Registers
  // ************************************************
  reg [31:0] cfg_r;
  reg [31:0] pwd_r;
  reg [31:0] id_r;
  reg auth_r;
  reg [2:0] fail_r;
  reg [1:0] st_r;
  wire [7:0] start_page = cfg_r[`TAS_CFG_START_LSB +: 8];
  wire scope_rw = cfg_r[`TAS_CFG_SCOPE_BIT];
  wire [2:0] limit = cfg_r[`TAS_CFG_LIMIT_LSB +: 3];
  wire locked = (limit != 3'b000) && (fail_r >= limit);
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire sess_drop = wb_wr && (wb_adr_i == `TAS_OFS_SESS) && wb_sel_i[0] && wb_dat_i[0];

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cfg_r <= `TAS_CFG_RST;
      pwd_r <= `TAS_PWD_RST;
      id_r <= {8'h00, VIRTUAL_CARD_TYPE_CODE_RST, `TAS_PACK_RST};
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_wr && (wb_adr_i == `TAS_OFS_CFG))
      begin
        cfg_r <= merge(cfg_r, wb_dat_i, wb_sel_i) & 32'h0000_0FFF;
      end
      if (wb_wr && (wb_adr_i == `TAS_OFS_PWD))
      begin
        pwd_r <= merge(pwd_r, wb_dat_i, wb_sel_i);
      end
      if (wb_wr && (wb_adr_i == `TAS_OFS_ID))
      begin
        id_r <= merge(id_r, wb_dat_i, wb_sel_i) & 32'h00FF_FFFF;
      end
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `TAS_OFS_CFG: wb_dat_o <= cfg_r;
          `TAS_OFS_ID: wb_dat_o <= id_r;
          `TAS_OFS_STAT: wb_dat_o <= {26'h000_0000, (st_r != ST_IDLE), locked, fail_r, auth_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************
  // Access gates
  // ************************************************
  // Counter reads never pass through these gates, so they stay open
  wire in_protection_scope_bit = (page_i >= start_page);
  wire granted = auth_r & ~locked;
  assign wr_ok_o = ~in_protection_scope_bit | granted;
  assign rd_ok_o = ~in_protection_scope_bit | ~scope_rw | granted;

  // ************************************************
  // Frame receive and command decode
  // ************************************************
  reg [7:0] rx_sh_r;
  reg [2:0] rx_bit_r;
  reg [5:0] rx_cnt_r;
  reg [7:0] rx_buf_r [0:5];
  reg [2:0] rsp_r;
  reg [5:0] rsp_len_r;
  reg [3:0] nak_r;
  reg [7:0] tear_r;
  reg [13:0] wait_r;
  reg [7:0] tx_sh_r;
  reg [3:0] tx_bits_r;
  reg [5:0] tx_idx_r;
  reg [5:0] tx_tot_r;
  wire [15:0] crc;
  wire rx_byte = (st_r == ST_RX) && frm_on && lk_rise && (rx_bit_r == 3'd7);
  wire [7:0] rx_new = {dat_s_r[1], rx_sh_r[7:1]};
  wire [7:0] cmd = rx_buf_r[0];
  wire [7:0] arg = rx_buf_r[1];
  wire [31:0] pwd_rx = {rx_buf_r[4], rx_buf_r[3], rx_buf_r[2], rx_buf_r[1]};
  wire crc_ok = (crc == 16'h0000) && (rx_cnt_r >= 6'd3);
  wire known = (cmd == `TAS_OP_PWD) || (cmd == `TAS_OP_SIG) || (cmd == `TAS_OP_TEAR) || (cmd == `TAS_OP_VIRTUAL_CARD_SELECT_COMMAND);
  wire pwd_match = (pwd_rx == pwd_r);
  wire [255:0] sig_sh = SIG_VALUE >> {tx_idx_r, 3'b000};
  reg [7:0] data_byte;
  always @*
  begin
    case (rsp_r)
      RSP_PACK: data_byte = tx_idx_r[0] ? id_r[15:8] : id_r[7:0];
      RSP_SIG: data_byte = sig_sh[7:0];
      RSP_TEAR: data_byte = tear_r;
      RSP_VCT: data_byte = id_r[23:16];
      default: data_byte = 8'h00;
    endcase
  end
  wire [7:0] tx_byte = (tx_idx_r < rsp_len_r) ? data_byte : ((tx_idx_r == rsp_len_r) ? crc[7:0] : crc[15:8]);
  wire tx_load = (st_r == ST_TX) && lk_fall && (tx_bits_r == 4'd0) && (tx_idx_r < tx_tot_r);
  wire crc_en = rx_byte || (tx_load && (tx_idx_r < rsp_len_r));
  wire [7:0] crc_in = (st_r == ST_RX) ? rx_new : tx_byte;
  wire crc_clr = ((st_r == ST_IDLE) && frm_beg) || ((st_r == ST_RX) && frm_end);

  tas_crc u_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(crc_clr),
    .en_i(crc_en),
    .byte_i(crc_in),
    .crc_o(crc)
  );

  integer j;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= ST_IDLE;
      rx_sh_r <= 8'h00;
      rx_bit_r <= 3'd0;
      rx_cnt_r <= 6'd0;
      for (j = 0; j < 6; j = j + 1)
      begin
        rx_buf_r[j] <= 8'h00;
      end
      rsp_r <= RSP_NAK;
      rsp_len_r <= 6'd0;
      nak_r <= 4'h0;
      tear_r <= 8'h00;
      wait_r <= 14'd0;
      auth_r <= 1'b0;
      fail_r <= 3'd0;
      tx_frm_o <= 1'b0;
      tx_dat_o <= 1'b0;
      tx_sh_r <= 8'h00;
      tx_bits_r <= 4'd0;
      tx_idx_r <= 6'd0;
      tx_tot_r <= 6'd0;
    end
    else
    begin
      if (sess_drop)
      begin
        auth_r <= 1'b0;
      end
      case (st_r)
        ST_IDLE:
        begin
          if (frm_beg)
          begin
            st_r <= ST_RX;
            rx_bit_r <= 3'd0;
            rx_cnt_r <= 6'd0;
          end
        end
        ST_RX:
        begin
          if (frm_on && lk_rise)
          begin
            rx_sh_r <= rx_new;
            rx_bit_r <= rx_bit_r + 3'd1;
            if (rx_bit_r == 3'd7)
            begin
              if (rx_cnt_r < 6'd6)
              begin
                rx_buf_r[rx_cnt_r[2:0]] <= rx_new;
              end
              if (rx_cnt_r != 6'd63)
              begin
                rx_cnt_r <= rx_cnt_r + 6'd1;
              end
            end
          end
          if (frm_end)
          begin
            // Unknown opcodes stay silent; another handler may own them
            st_r <= known ? ST_WAIT : ST_IDLE;
            wait_r <= 14'd0;
            rsp_r <= RSP_NAK;
            rsp_len_r <= 6'd0;
            if (!crc_ok)
            begin
              nak_r <= `TAS_NAK_CRC;
            end
            else if (cmd == `TAS_OP_PWD)
            begin
              if (rx_cnt_r != `TAS_LEN_PWD)
              begin
                nak_r <= `TAS_NAK_ARG;
              end
              else if (locked)
              begin
                nak_r <= `TAS_NAK_AUTH;
              end
              else if (pwd_match)
              begin
                auth_r <= 1'b1;
                fail_r <= 3'd0;
                rsp_r <= RSP_PACK;
                rsp_len_r <= 6'd2;
              end
              else
              begin
                nak_r <= `TAS_NAK_AUTH;
                // Single-cycle update; the count is not kept on power loss, rst_i clears it to zero
                if (limit != 3'b000)
                begin
                  fail_r <= fail_r + 3'd1;
                end
              end
            end
            else if (cmd == `TAS_OP_SIG)
            begin
              if ((rx_cnt_r == `TAS_LEN_SIG) && (arg == `TAS_SIG_ADDR))
              begin
                rsp_r <= RSP_SIG;
                rsp_len_r <= 6'd32;
              end
              else
              begin
                nak_r <= `TAS_NAK_ARG;
              end
            end
            else if (cmd == `TAS_OP_TEAR)
            begin
              if ((rx_cnt_r == `TAS_LEN_TEAR) && (arg <= `TAS_TEAR_MAX))
              begin
                tear_r <= tear_flag_i[{arg[1:0], 3'b000} +: 8];
                rsp_r <= RSP_TEAR;
                rsp_len_r <= 6'd1;
              end
              else
              begin
                nak_r <= `TAS_NAK_ARG;
              end
            end
            else
            begin
              if (rx_cnt_r == `TAS_LEN_VIRTUAL_CARD_SELECT_COMMAND)
              begin
                rsp_r <= RSP_VCT;
                rsp_len_r <= 6'd1;
              end
              else
              begin
                nak_r <= `TAS_NAK_ARG;
              end
            end
          end
        end
        ST_WAIT:
        begin
          wait_r <= wait_r + 14'd1;
          if (wait_r >= FDT_CYC[13:0] - 14'd1)
          begin
            st_r <= ST_TX;
            tx_frm_o <= 1'b1;
            tx_idx_r <= 6'd0;
            if (rsp_r == RSP_NAK)
            begin
              tx_sh_r <= {4'h0, nak_r};
              tx_bits_r <= 4'd4;
              tx_tot_r <= 6'd0;
            end
            else
            begin
              tx_bits_r <= 4'd0;
              tx_tot_r <= rsp_len_r + 6'd2;
            end
          end
        end
        default:
        begin
          if (lk_fall)
          begin
            if (tx_bits_r != 4'd0)
            begin
              tx_dat_o <= tx_sh_r[0];
              tx_sh_r <= tx_sh_r >> 1;
              tx_bits_r <= tx_bits_r - 4'd1;
            end
            else if (tx_load)
            begin
              tx_dat_o <= tx_byte[0];
              tx_sh_r <= tx_byte >> 1;
              tx_bits_r <= 4'd7;
              tx_idx_r <= tx_idx_r + 6'd1;
            end
            else
            begin
              tx_frm_o <= 1'b0;
              tx_dat_o <= 1'b0;
              st_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule // tas_cmd

// ---- tas_cmd_checker.sv ----
// Port checks for the tag command handler.
// Assumes one clock domain; bound into every handler instance.
`timescale 1ns/10ps
`include "tas_regs.vh"

module tas_cmd_checker #(
  parameter FDT_CYC = `TAS_FDT_CYC // Least answer wait
) (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Acknowledge
  input wire link_frm_i, // Reader frame
  input wire tx_frm_o, // Answer frame
  input wire tx_dat_o, // Answer bit
  input wire wr_ok_o, // Write allowed
  input wire rd_ok_o // Read allowed
);
  // ****************
  // Quiet-link counter
  // ****************
  logic [15:0] quiet_r;
  logic [15:0] quiet_nxt;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Saturates so a long idle link never wraps
  assign quiet_nxt = link_frm_i ? 16'h0000 : ((quiet_r == 16'hFFFF) ? quiet_r : quiet_r + 16'h0001);

  always @(posedge clk_i)
    if (rst_i)
      quiet_r <= 16'h0000;
    else
      quiet_r <= quiet_nxt;

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_ack_pulse: assert property (s_take |=> s_pulse)
    else $error("ack not one pulse one cycle after request");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_scope_order: assert property (!rd_ok_o |-> !wr_ok_o)
    else $error("read guarded but write open");
  a_answer_wait: assert property ($rose(tx_frm_o) |-> quiet_r >= FDT_CYC)
    else $error("answer before least wait");
  a_no_overlap: assert property (link_frm_i |-> !tx_frm_o)
    else $error("answer while reader sends");
  a_bit_hold: assert property ($changed(tx_dat_o) |=> $stable(tx_dat_o) [*4])
    else $error("answer bit too short");
  a_frame_len: assert property ($rose(tx_frm_o) |=> tx_frm_o [*8])
    else $error("answer frame too short");
endmodule // tas_cmd_checker

bind tas_cmd tas_cmd_checker #(.FDT_CYC(FDT_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_frm_i(link_frm_i), .tx_frm_o(tx_frm_o),
  .tx_dat_o(tx_dat_o), .wr_ok_o(wr_ok_o), .rd_ok_o(rd_ok_o));

// ---- tas_reader.sv ----
// Reader model: sends framed commands bit-serially and collects the answer.
// Assumes the tag samples at rising link edges and answers at falling ones.
`timescale 1ns/10ps

module tas_reader (
  output logic link_clk_o, // Link bit clock
  output logic link_frm_o, // Frame active
  output logic link_dat_o, // Data bit
  input wire tx_frm_i, // Answer frame
  input wire tx_dat_i // Answer bit
);
  // ****************
  // Frame exchange
  // ****************
  logic [7:0] cmd [0:24];
  logic [299:0] rsp;

  initial
  begin
    link_clk_o = 1'b0;
    link_frm_o = 1'b0;
    link_dat_o = 1'b1;
  end

  function automatic [15:0] crc8(input [15:0] c, input [7:0] b);
    int j;
    c = c ^ {8'h00, b};
    for (j = 0; j < 8; j++)
      c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    return c;
  endfunction

  // Clock runs only for a command and its answer
  task automatic xfer(input int n, input logic bad, output int nb);
    logic [15:0] c;
    int i, w;
    c = 16'h6363;
    for (i = 0; i < n; i++)
      c = crc8(c, cmd[i]);
    cmd[n] = c[7:0] ^ {7'h00, bad};
    cmd[n+1] = c[15:8];
    #3 link_frm_o = 1'b1;
    for (i = 0; i < (n + 2) * 8; i++)
    begin
      link_dat_o = cmd[i / 8][i % 8];
      #40 link_clk_o = 1'b1;
      #40 link_clk_o = 1'b0;
    end
    link_frm_o = 1'b0;
    link_dat_o = ~link_dat_o;
    nb = 0;
    w = 0;
    rsp = '0;
    // Bounded far below the 5 ms reader timeout
    do
    begin
      #40 link_clk_o = 1'b1;
      #30 if (tx_frm_i && nb < 300)
      begin
        rsp[nb] = tx_dat_i;
        nb++;
      end
      #10 link_clk_o = 1'b0;
      w++;
    end while ((nb == 0 || tx_frm_i) && w < 2000);
  endtask
endmodule // tas_reader

// ---- tb_top.sv ----
// Self-checking bench for the tag command handler.
// Assumes the reader model drives the link; bus tasks speak classic Wishbone.
`timescale 1ns/10ps
`include "tas_regs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_top;
  localparam [255:0] SIG = {8{32'h0F1E_2D3C}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [23:0] tear_flag_i = 24'hBD_77BD;
  logic [7:0] page_i = 8'hFF;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, link_clk_i, link_frm_i, link_dat_i, tx_frm_o, tx_dat_o, wr_ok_o, rd_ok_o;
  logic [7:0] ed [0:33];
  logic [31:0] q;
  int mismatches = 0;
  int samples_checked = 0;
  int i;

  always #5 clk_i = ~clk_i;

  tas_cmd #(.FDT_CYC(20), .SIG_VALUE(SIG), .VIRTUAL_CARD_TYPE_CODE_RST(8'h00)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i),
    .link_frm_i(link_frm_i), .link_dat_i(link_dat_i), .tx_frm_o(tx_frm_o), .tx_dat_o(tx_dat_o),
    .tear_flag_i(tear_flag_i), .page_i(page_i), .wr_ok_o(wr_ok_o), .rd_ok_o(rd_ok_o));

  tas_reader u_rdr (.link_clk_o(link_clk_i), .link_frm_o(link_frm_i), .link_dat_o(link_dat_i),
    .tx_frm_i(tx_frm_o), .tx_dat_i(tx_dat_o));

  // ****************
  // Access tasks
  // ****************
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    `CHK(wb_ack_o, 1'b1)
    // A bus that never answers ends the run here
    if (wb_ack_o !== 1'b1)
      close_out();
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask

  task gate(input logic [7:0] p, input logic w, input logic r);
    page_i <= p;
    repeat (2) @(posedge clk_i);
    `CHK({wr_ok_o, rd_ok_o}, {w, r})
  endtask

  task setc(input logic [7:0] a, b, c, d, e);
    {u_rdr.cmd[0], u_rdr.cmd[1], u_rdr.cmd[2], u_rdr.cmd[3], u_rdr.cmd[4]} = {a, b, c, d, e};
  endtask

  // Answer is k data bytes plus CRC, or a 4-bit code when k is zero
  task run(input int n, input int k, input logic [3:0] nak, input logic bad);
    logic [299:0] e, m;
    logic [15:0] c;
    int j, nb, eb;
    // Start each frame a fixed offset after a clock edge
    @(posedge clk_i);
    u_rdr.xfer(n, bad, nb);
    c = 16'h6363;
    e = '0;
    for (j = 0; j < k; j++)
    begin
      e[j*8+:8] = ed[j];
      c = u_rdr.crc8(c, ed[j]);
    end
    e[k*8+:16] = c;
    if (k == 0)
      e = {296'h0, nak};
    eb = (k == 0) ? 4 : k * 8 + 16;
    m = (300'h1 << eb) - 300'h1;
    // At most one stale sample before the first answer bit
    `CHK((nb >= eb) && (nb <= eb + 1), 1'b1)
    `CHK((u_rdr.rsp >> (nb - eb)) & m, e)
    if (nb < eb)
      close_out();
  endtask

  task close_out();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TAS_OFS_CFG, `TAS_CFG_RST);
    rd(`TAS_OFS_STAT, 32'h0000_0000);
    rd(`TAS_OFS_PWD, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    gate(8'hFF, 1'b0, 1'b1);
    gate(8'hFE, 1'b1, 1'b1);
    setc(`TAS_OP_PWD, 8'h00, 8'h00, 8'h00, 8'h00);
    run(5, 0, `TAS_NAK_AUTH, 1'b0);
    rd(`TAS_OFS_STAT, 32'h0000_0000);
    wb(1'b1, `TAS_OFS_CFG, 32'h0000_0510);
    wb(1'b1, `TAS_OFS_PWD, 32'h1234_5678);
    wb(1'b1, `TAS_OFS_ID, 32'h005A_BEEF);
    rd(`TAS_OFS_CFG, 32'h0000_0510);
    gate(8'h10, 1'b0, 1'b0);
    gate(8'h0F, 1'b1, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      setc(`TAS_OP_TEAR, 8'(i), 8'h00, 8'h00, 8'h00);
      ed[0] = tear_flag_i[(i % 3)*8+:8];
      run(2, (i < 3) ? 1 : 0, `TAS_NAK_ARG, 1'b0);
    end
    setc(`TAS_OP_SIG, `TAS_SIG_ADDR, 8'h00, 8'h00, 8'h00);
    for (i = 0; i < 32; i++)
      ed[i] = SIG[i*8+:8];
    run(2, 32, 4'h0, 1'b0);
    setc(`TAS_OP_SIG, 8'h01, 8'h00, 8'h00, 8'h00);
    run(2, 0, `TAS_NAK_ARG, 1'b0);
    setc(`TAS_OP_TEAR, 8'h00, 8'h00, 8'h00, 8'h00);
    run(2, 0, `TAS_NAK_CRC, 1'b1);
    u_rdr.cmd[0] = `TAS_OP_VIRTUAL_CARD_SELECT_COMMAND;
    for (i = 1; i < 21; i++)
      u_rdr.cmd[i] = 8'(i * 7);
    ed[0] = 8'h5A;
    run(21, 1, 4'h0, 1'b0);
    run(20, 0, `TAS_NAK_ARG, 1'b0);
    setc(`TAS_OP_PWD, 8'h00, 8'h00, 8'h00, 8'h00);
    run(5, 0, `TAS_NAK_AUTH, 1'b0);
    rd(`TAS_OFS_STAT, 32'h0000_0002);
    setc(`TAS_OP_PWD, 8'h78, 8'h56, 8'h34, 8'h12);
    ed[0] = 8'hEF;
    ed[1] = 8'hBE;
    run(5, 2, 4'h0, 1'b0);
    rd(`TAS_OFS_STAT, 32'h0000_0001);
    gate(8'h10, 1'b1, 1'b1);
    wb(1'b1, `TAS_OFS_SESS, 32'h0000_0001);
    gate(8'h10, 1'b0, 1'b0);
    setc(`TAS_OP_PWD, 8'h00, 8'h00, 8'h00, 8'h00);
    run(5, 0, `TAS_NAK_AUTH, 1'b0);
    run(5, 0, `TAS_NAK_AUTH, 1'b0);
    rd(`TAS_OFS_STAT, 32'h0000_0014);
    setc(`TAS_OP_PWD, 8'h78, 8'h56, 8'h34, 8'h12);
    run(5, 0, `TAS_NAK_AUTH, 1'b0);
    gate(8'h10, 1'b0, 1'b0);
    close_out();
  end
endmodule // tb_top
